// ===== hw/mac_statistics_counters.sv
// statistics counters, promiscuous control and multicast address filter
`timescale 1ns/1ps
module mac_statistics_counters
    import mac_stats_pkg::*;
(
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_tx_done,
    input  wire tx_report_s           i_tx,
    input  wire logic [ATT_W-1:0]     i_max_attempt_count,
    input  wire logic                 i_rx_done,
    input  wire rx_report_s           i_rx,
    input  wire logic [ADDR_W-1:0]    i_station_addr,
    input  wire logic                 i_promisc_set,
    input  wire logic                 i_promisc_value,
    input  wire logic                 i_group_add,
    input  wire logic                 i_group_del,
    input  wire logic [ADDR_W-1:0]    i_group_addr,
    input  wire logic [GRP_IDX_W-1:0] i_list_index,
    output logic                      o_promiscuous_enable,
    output logic                      o_addr_accept,
    output logic [ADDR_W-1:0]         o_list_entry,
    output logic                      o_list_valid,
    output logic                      o_list_full,
    output stats_s                    o_stats
);

    // address helpers used by both transmit and receive paths
    function automatic logic is_bcast(input logic [ADDR_W-1:0] a);
        return a == BCAST_ADDR;
    endfunction

    function automatic logic is_mcast(input logic [ADDR_W-1:0] a);
        return a[GROUP_BIT] && (a != BCAST_ADDR);
    endfunction

    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input logic en);
        return c + {{(CNT_W-1){1'b0}}, en};
    endfunction

    // group table: small array, searched in parallel
    logic [ADDR_W-1:0]    grp_addr_q [GRP_DEPTH];
    logic [GRP_DEPTH-1:0] grp_valid_q;
    logic                 promisc_q;
    logic [ADDR_W-1:0]    list_entry_q;
    logic                 list_valid_q;
    stats_s               cnt_q;
    stats_s               cnt_d;

    function automatic logic [GRP_DEPTH-1:0] match_vec(input logic [ADDR_W-1:0] a);
        logic [GRP_DEPTH-1:0] m;
        m = '0;
        for (int i = 0; i < GRP_DEPTH; i++) begin
            m[i] = grp_valid_q[i] && (grp_addr_q[i] == a);
        end
        return m;
    endfunction

    function automatic logic [GRP_IDX_W-1:0] first_free(input logic [GRP_DEPTH-1:0] v);
        logic [GRP_IDX_W-1:0] idx;
        idx = '0;
        for (int i = GRP_DEPTH - 1; i >= 0; i--) begin
            if (!v[i]) begin
                idx = GRP_IDX_W'(i);
            end
        end
        return idx;
    endfunction

    // filter decision on the current receive report
    wire logic rx_is_bcast   = is_bcast(i_rx.dest_addr_field);
    wire logic rx_is_mcast   = is_mcast(i_rx.dest_addr_field);
    wire logic rx_grp_hit    = |match_vec(i_rx.dest_addr_field);
    wire logic rx_station    = i_rx.dest_addr_field == i_station_addr;
    wire logic normal_accept = rx_station || rx_is_bcast || (rx_is_mcast && rx_grp_hit);
    assign o_addr_accept = promisc_q || normal_accept;

    // table maintenance; add of an address already present is a no-op
    wire logic                 add_hit  = |match_vec(i_group_addr);
    wire logic                 add_ok   = i_group_add && i_group_addr[GROUP_BIT] && !add_hit
                                          && !(&grp_valid_q);
    wire logic [GRP_IDX_W-1:0] add_slot = first_free(grp_valid_q);
    wire logic [GRP_DEPTH-1:0] del_vec  = i_group_del ? match_vec(i_group_addr) : '0;
    assign o_list_full = &grp_valid_q;

    // transmit events; an internal fault hides the frame from every other count
    wire logic tx_ev      = i_tx_done && !i_tx.internal_fault;
    wire logic tx_ok      = tx_ev && i_tx.tx_good_status;
    wire logic inc_xs     = tx_ev && !i_tx.tx_good_status
                            && (i_tx.attempts == i_max_attempt_count);
    wire logic inc_tx_los = i_tx_done && i_tx.internal_fault;
    wire logic inc_cs     = tx_ev && i_tx.carrier_sense_fail_flag
                            && (i_tx.attempts == FIRST_ATTEMPT);
    wire logic inc_mc_tx  = tx_ok && is_mcast(i_tx.dest_addr_field);
    wire logic inc_bc_tx  = tx_ok && is_bcast(i_tx.dest_addr_field);
    wire logic inc_defer  = tx_ev && i_tx.excess_deferral_flag;

    // receive events, only for frames the filter let through
    wire logic rx_acc     = i_rx_done && o_addr_accept;
    wire logic rx_ev      = rx_acc && !i_rx.internal_fault;
    wire logic len_oor    = i_rx.length_field > MAX_DATA_LEN;
    wire logic len_bad    = !len_oor && ((i_rx.length_field < MIN_UNPAD_LEN)
                            || (i_rx.length_field != i_rx.data_octets));
    wire logic rx_err     = i_rx.oversize_frame_status || i_rx.fcs_error
                            || i_rx.align_error || len_bad;
    wire logic rx_ok      = rx_ev && i_rx.rx_good_status && !rx_err;
    wire logic inc_rx_los = rx_acc && i_rx.internal_fault;
    wire logic inc_mc_rx  = rx_ok && rx_is_mcast && rx_grp_hit;
    wire logic inc_bc_rx  = rx_ok && rx_is_bcast;
    wire logic inc_len    = rx_ev && len_bad;
    wire logic inc_oor    = rx_ev && len_oor;
    wire logic inc_long   = rx_ev && i_rx.oversize_frame_status;

    // next counter values; plain add wraps to zero at full scale
    always_comb begin
        cnt_d = cnt_q;
        cnt_d.excess_collision_abort_count = bump(cnt_q.excess_collision_abort_count, inc_xs);
        cnt_d.internal_tx_loss_count    = bump(cnt_q.internal_tx_loss_count, inc_tx_los);
        cnt_d.carrier_sense_error_count = bump(cnt_q.carrier_sense_error_count, inc_cs);
        cnt_d.mcast_tx_count            = bump(cnt_q.mcast_tx_count, inc_mc_tx);
        cnt_d.bcast_tx_count            = bump(cnt_q.bcast_tx_count, inc_bc_tx);
        cnt_d.excess_deferral_count     = bump(cnt_q.excess_deferral_count, inc_defer);
        cnt_d.internal_rx_loss_count    = bump(cnt_q.internal_rx_loss_count, inc_rx_los);
        cnt_d.mcast_rx_count            = bump(cnt_q.mcast_rx_count, inc_mc_rx);
        cnt_d.bcast_rx_count            = bump(cnt_q.bcast_rx_count, inc_bc_rx);
        cnt_d.length_mismatch_count     = bump(cnt_q.length_mismatch_count, inc_len);
        cnt_d.length_out_of_range_count = bump(cnt_q.length_out_of_range_count, inc_oor);
        cnt_d.oversize_frame_count      = bump(cnt_q.oversize_frame_count, inc_long);
        // octets added in one cycle, so any frame rate up to one per clock is kept up with
        if (rx_ok) begin
            cnt_d.rx_good_octet_count = cnt_q.rx_good_octet_count
                                        + CNT_W'(i_rx.octet_total);
        end
    end

    // counters clear only on hardware reset; management has no clear path
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            cnt_q <= {$bits(stats_s){1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // promiscuous setting
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            promisc_q <= 1'b0;
        end else if (i_promisc_set) begin
            promisc_q <= i_promisc_value;
        end
    end

    // group table valid bits; delete wins if both strobes name one address
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            grp_valid_q <= '0;
        end else begin
            grp_valid_q <= (grp_valid_q & ~del_vec)
                           | ((add_ok && !i_group_del) ? (GRP_DEPTH'(1) << add_slot) : '0);
        end
    end

    // address storage needs no reset; guarded by the valid bits
    always_ff @(posedge i_clock) begin
        if (add_ok && !i_group_del) begin
            grp_addr_q[add_slot] <= i_group_addr;
        end
    end

    // list readback, one cycle after the index is presented
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            list_entry_q <= '0;
            list_valid_q <= 1'b0;
        end else begin
            list_entry_q <= grp_valid_q[i_list_index] ? grp_addr_q[i_list_index] : '0;
            list_valid_q <= grp_valid_q[i_list_index];
        end
    end

    assign o_promiscuous_enable = promisc_q;
    assign o_list_entry         = list_entry_q;
    assign o_list_valid         = list_valid_q;
    assign o_stats              = cnt_q;

    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    property p_xs_abort;
        i_tx_done && !i_tx.internal_fault && !i_tx.tx_good_status
        && (i_tx.attempts == i_max_attempt_count)
        |=> o_stats.excess_collision_abort_count
            == $past(o_stats.excess_collision_abort_count) + 32'h00000001;
    endproperty
    a_xs_abort: assert property (p_xs_abort) else $error("abort count missed");

    property p_tx_fault_excl;
        i_tx_done && i_tx.internal_fault
        |=> $stable(o_stats.mcast_tx_count) && $stable(o_stats.bcast_tx_count)
            && $stable(o_stats.excess_deferral_count)
            && $stable(o_stats.carrier_sense_error_count)
            && (o_stats.internal_tx_loss_count
                == $past(o_stats.internal_tx_loss_count) + 32'h00000001);
    endproperty
    a_tx_fault_excl: assert property (p_tx_fault_excl) else $error("tx fault leak");

    property p_cs_err;
        i_tx_done && !i_tx.internal_fault && i_tx.carrier_sense_fail_flag
        && (i_tx.attempts != FIRST_ATTEMPT)
        |=> $stable(o_stats.carrier_sense_error_count);
    endproperty
    a_cs_err: assert property (p_cs_err) else $error("cs error counted on collision");

    property p_rx_octets;
        rx_ok |=> o_stats.rx_good_octet_count
                  == $past(o_stats.rx_good_octet_count) + 32'($past(i_rx.octet_total));
    endproperty
    a_rx_octets: assert property (p_rx_octets) else $error("octet sum wrong");

    property p_rx_fault_excl;
        i_rx_done && i_rx.internal_fault
        |=> $stable(o_stats.rx_good_octet_count) && $stable(o_stats.mcast_rx_count)
            && $stable(o_stats.bcast_rx_count) && $stable(o_stats.oversize_frame_count)
            && $stable(o_stats.length_mismatch_count);
    endproperty
    a_rx_fault_excl: assert property (p_rx_fault_excl) else $error("rx fault leak");

    property p_promisc_read;
        i_promisc_set |=> o_promiscuous_enable == $past(i_promisc_value) ##1
                          ($past(i_promisc_set) || $stable(o_promiscuous_enable));
    endproperty
    a_promisc_read: assert property (p_promisc_read) else $error("promisc readback");

    property p_promisc_accept;
        o_promiscuous_enable |-> o_addr_accept;
    endproperty
    a_promisc_accept: assert property (p_promisc_accept) else $error("promisc reject");

    property p_filter_normal;
        !o_promiscuous_enable && !i_rx.dest_addr_field[GROUP_BIT]
        && (i_rx.dest_addr_field != i_station_addr) |-> !o_addr_accept;
    endproperty
    a_filter_normal: assert property (p_filter_normal) else $error("stray unicast");

    sequence s_list_add;
        i_group_add && !i_group_del && i_group_addr[GROUP_BIT] && !(&grp_valid_q)
        && !add_hit;
    endsequence
    property p_list_add;
        s_list_add |=> grp_valid_q[$past(add_slot)]
                       && (grp_addr_q[$past(add_slot)] == $past(i_group_addr));
    endproperty
    a_list_add: assert property (p_list_add) else $error("group add lost");

    property p_bcast_tx;
        i_tx_done && !i_tx.internal_fault && i_tx.tx_good_status
        && is_bcast(i_tx.dest_addr_field)
        |=> $stable(o_stats.mcast_tx_count)
            && (o_stats.bcast_tx_count == $past(o_stats.bcast_tx_count) + 32'h00000001);
    endproperty
    a_bcast_tx: assert property (p_bcast_tx) else $error("bcast tx count");

    property p_bcast_rx_err;
        i_rx_done && (i_rx.fcs_error || i_rx.align_error || i_rx.oversize_frame_status)
        |=> $stable(o_stats.bcast_rx_count) && $stable(o_stats.mcast_rx_count);
    endproperty
    a_bcast_rx_err: assert property (p_bcast_rx_err) else $error("errored frame as good");

    property p_oversize;
        i_rx_done && o_addr_accept && !i_rx.internal_fault && i_rx.oversize_frame_status
        |=> o_stats.oversize_frame_count
            == $past(o_stats.oversize_frame_count) + 32'h00000001;
    endproperty
    a_oversize: assert property (p_oversize) else $error("oversize not counted");

    // accepted reception that no internal fault hides
    sequence s_rx_taken;
        i_rx_done && o_addr_accept && !i_rx.internal_fault;
    endsequence

    // clean reception: good status, no error, length a type value or a match
    sequence s_rx_clean;
        s_rx_taken ##0 (i_rx.rx_good_status && !i_rx.fcs_error && !i_rx.align_error
        && !i_rx.oversize_frame_status && ((i_rx.length_field > MAX_DATA_LEN)
        || ((i_rx.length_field >= MIN_UNPAD_LEN) && (i_rx.length_field == i_rx.data_octets))));
    endsequence

    property p_mcast_rx;
        s_rx_clean ##0 (is_mcast(i_rx.dest_addr_field) && rx_grp_hit)
        |=> o_stats.mcast_rx_count == $past(o_stats.mcast_rx_count) + 32'h00000001;
    endproperty
    a_mcast_rx: assert property (p_mcast_rx) else $error("mcast rx count");

    property p_bcast_rx;
        s_rx_clean ##0 is_bcast(i_rx.dest_addr_field)
        |=> o_stats.bcast_rx_count == $past(o_stats.bcast_rx_count) + 32'h00000001;
    endproperty
    a_bcast_rx: assert property (p_bcast_rx) else $error("bcast rx count");

    // short length fields count here whatever the octet count says
    property p_len_bad;
        s_rx_taken ##0 ((i_rx.length_field < MIN_UNPAD_LEN)
        || ((i_rx.length_field <= MAX_DATA_LEN) && (i_rx.length_field != i_rx.data_octets)))
        |=> o_stats.length_mismatch_count
            == $past(o_stats.length_mismatch_count) + 32'h00000001;
    endproperty
    a_len_bad: assert property (p_len_bad) else $error("length count");

    property p_len_oor;
        s_rx_taken ##0 (i_rx.length_field > MAX_DATA_LEN)
        |=> o_stats.length_out_of_range_count
            == $past(o_stats.length_out_of_range_count) + 32'h00000001;
    endproperty
    a_len_oor: assert property (p_len_oor) else $error("range count");

    // one bump per report however long the deferral lasted
    property p_defer;
        i_tx_done && !i_tx.internal_fault && i_tx.excess_deferral_flag
        |=> o_stats.excess_deferral_count
            == $past(o_stats.excess_deferral_count) + 32'h00000001;
    endproperty
    a_defer: assert property (p_defer) else $error("deferral count");

    // readback register follows the slot picked one cycle earlier
    wire logic              list_hit  = grp_valid_q[i_list_index];
    wire logic [ADDR_W-1:0] list_word = grp_addr_q[i_list_index];
    property p_list_read;
        list_hit |=> o_list_valid && (o_list_entry == $past(list_word));
    endproperty
    a_list_read: assert property (p_list_read) else $error("list readback");

    // no report, no movement: nothing outside reset can clear a counter
    property p_hold;
        !i_rx_done && !i_tx_done |=> $stable(o_stats);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved idle");

    property p_wrap;
        inc_long && (&o_stats.oversize_frame_count) |=> o_stats.oversize_frame_count == CNT_RESET;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

endmodule

// ===== hw/mac_stats_pkg.sv
// constants, report structs and counter layout for the mac statistics block
package mac_stats_pkg;
    localparam int          ADDR_W         = 48;
    localparam int          CNT_W          = 32;
    localparam int          LEN_W          = 16;
    localparam int          ATT_W          = 5;
    localparam int          GRP_DEPTH      = 8;
    localparam int          GRP_IDX_W      = 3;
    localparam logic [LEN_W-1:0] MIN_UNPAD_LEN = 16'h002E;
    localparam logic [LEN_W-1:0] MAX_DATA_LEN  = 16'h05DC;
    localparam logic [ADDR_W-1:0] BCAST_ADDR   = 48'hFFFFFFFFFFFF;
    localparam int          GROUP_BIT      = 40;
    localparam logic [ATT_W-1:0]  FIRST_ATTEMPT = 5'h01;
    localparam logic [CNT_W-1:0]  CNT_RESET     = 32'h00000000;

    // one report per finished transmit request
    typedef struct packed {
        logic              tx_good_status;
        logic              internal_fault;
        logic              carrier_sense_fail_flag;
        logic              excess_deferral_flag;
        logic [ATT_W-1:0]  attempts;
        logic [ADDR_W-1:0] dest_addr_field;
    } tx_report_s;

    // one report per finished reception
    typedef struct packed {
        logic              rx_good_status;
        logic              internal_fault;
        logic              oversize_frame_status;
        logic              fcs_error;
        logic              align_error;
        logic [LEN_W-1:0]  length_field;
        logic [LEN_W-1:0]  data_octets;
        logic [LEN_W-1:0]  octet_total;
        logic [ADDR_W-1:0] dest_addr_field;
    } rx_report_s;

    typedef struct packed {
        logic [CNT_W-1:0] excess_collision_abort_count;
        logic [CNT_W-1:0] internal_tx_loss_count;
        logic [CNT_W-1:0] carrier_sense_error_count;
        logic [CNT_W-1:0] mcast_tx_count;
        logic [CNT_W-1:0] bcast_tx_count;
        logic [CNT_W-1:0] excess_deferral_count;
        logic [CNT_W-1:0] rx_good_octet_count;
        logic [CNT_W-1:0] internal_rx_loss_count;
        logic [CNT_W-1:0] mcast_rx_count;
        logic [CNT_W-1:0] bcast_rx_count;
        logic [CNT_W-1:0] length_mismatch_count;
        logic [CNT_W-1:0] length_out_of_range_count;
        logic [CNT_W-1:0] oversize_frame_count;
    } stats_s;
endpackage

// ===== testbench/mac_frame_reporter.sv
// behavioural model of the mac transmit and receive frame status logic
`timescale 1ns/1ps
module mac_frame_reporter
    import mac_stats_pkg::*;
(
    input  wire logic i_clock,
    output logic       o_tx_done,
    output tx_report_s o_tx,
    output logic       o_rx_done,
    output rx_report_s o_rx
);
    // quiet start, no report pending
    initial begin
        o_tx_done = 1'b0;
        o_tx      = '0;
        o_rx_done = 1'b0;
        o_rx      = '0;
    end

    // one-cycle report; fields inverted afterwards so a stale report never
    // looks valid to a design that samples outside the pulse
    task automatic send_tx(input tx_report_s r);
        @(negedge i_clock);
        o_tx_done = 1'b1;
        o_tx      = r;
        @(negedge i_clock);
        o_tx_done = 1'b0;
        o_tx      = ~r;
    endtask

    // same framing on the receive side
    task automatic send_rx(input rx_report_s r);
        @(negedge i_clock);
        o_rx_done = 1'b1;
        o_rx      = r;
        @(negedge i_clock);
        o_rx_done = 1'b0;
        o_rx      = ~r;
    endtask

    // fields only, no done pulse; lets the bench look at the filter at leisure
    task automatic show_rx(input rx_report_s r);
        @(negedge i_clock);
        o_rx = r;
        @(negedge i_clock);
    endtask
endmodule

// ===== testbench/mac_statistics_counters_tb_top.sv
// self-checking bench for the mac statistics counters
`timescale 1ns/1ps
module mac_statistics_counters_tb_top import mac_stats_pkg::*;;
    localparam int               SW    = $bits(stats_s);
    localparam logic [ADDR_W-1:0] STN  = 48'h020000000001;
    localparam logic [ADDR_W-1:0] UNI  = 48'h020000000099;
    localparam logic [ADDR_W-1:0] GRP  = 48'h01005E000001;
    localparam logic [ATT_W-1:0]  LIM  = 5'h10;
    localparam logic [LEN_W-1:0]  OCT  = 16'h0040;
    logic                 clock;
    logic                 rst_b;
    logic                 tx_done;
    tx_report_s           tx;
    logic                 rx_done;
    rx_report_s           rx;
    logic                 promisc_set;
    logic                 promisc_value;
    logic                 group_add;
    logic                 group_del;
    logic [ADDR_W-1:0]    group_addr;
    logic [GRP_IDX_W-1:0] list_index;
    logic                 promisc_en;
    logic [ADDR_W-1:0]    list_entry;
    logic                 list_valid;
    logic                 addr_accept;
    logic                 list_full;
    stats_s               stats;
    stats_s               exp;
    int                   miscompares;
    int                   samples_checked;
    int                   cycles;

    mac_frame_reporter i_far (.i_clock(clock), .o_tx_done(tx_done), .o_tx(tx),
        .o_rx_done(rx_done), .o_rx(rx));

    mac_statistics_counters i_dut (.i_clock(clock), .i_rst_b(rst_b), .i_tx_done(tx_done),
        .i_tx(tx), .i_max_attempt_count(LIM), .i_rx_done(rx_done), .i_rx(rx),
        .i_station_addr(STN), .i_promisc_set(promisc_set), .i_promisc_value(promisc_value),
        .i_group_add(group_add), .i_group_del(group_del), .i_group_addr(group_addr),
        .i_list_index(list_index), .o_promiscuous_enable(promisc_en),
        .o_addr_accept(addr_accept),
        .o_list_entry(list_entry), .o_list_valid(list_valid), .o_list_full(list_full),
        .o_stats(stats));

    // 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic close_out();
        $display("compared %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard; the whole run needs under a hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic compare(input logic [SW-1:0] got, input logic [SW-1:0] want);
        samples_checked++;
        if (got !== want) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    function automatic tx_report_s mk_tx(logic g, logic f, logic c, logic d,
                                         logic [ATT_W-1:0] a, logic [ADDR_W-1:0] t);
        return '{g, f, c, d, a, t};
    endfunction

    function automatic rx_report_s mk_rx(logic g, logic f, logic o, logic e,
        logic [LEN_W-1:0] l, logic [LEN_W-1:0] n, logic [LEN_W-1:0] s, logic [ADDR_W-1:0] t);
        return '{g, f, o, e, 1'b0, l, n, s, t};
    endfunction

    // caller bumps exp first, then the whole counter set is compared
    task automatic tx_step(input tx_report_s r);
        i_far.send_tx(r);
        compare(stats, exp);
    endtask

    task automatic rx_step(input rx_report_s r);
        i_far.send_rx(r);
        compare(stats, exp);
    endtask

    task automatic set_promisc(input logic v);
        @(negedge clock);
        promisc_set   = 1'b1;
        promisc_value = v;
        @(negedge clock);
        promisc_set   = 1'b0;
        compare(SW'(promisc_en), SW'(v));
    endtask

    // group table change, then readback of slot 0 one cycle later
    task automatic group_op(input logic add, input logic [ADDR_W:0] want);
        @(negedge clock);
        group_add  = add;
        group_del  = ~add;
        group_addr = GRP;
        list_index = 3'h0;
        @(negedge clock);
        group_add  = 1'b0;
        group_del  = 1'b0;
        @(negedge clock);
        compare(SW'({list_valid, list_entry}), SW'(want));
    endtask

    task automatic t_reset();
        compare(stats, '0);
        compare(SW'({promisc_en, list_valid}), '0);
    endtask

    task automatic t_tx();
        exp.bcast_tx_count += 32'h1;
        tx_step(mk_tx(1'b1, 1'b0, 1'b0, 1'b0, FIRST_ATTEMPT, BCAST_ADDR));
        exp.mcast_tx_count += 32'h1;
        tx_step(mk_tx(1'b1, 1'b0, 1'b0, 1'b0, FIRST_ATTEMPT, GRP));
        exp.carrier_sense_error_count += 32'h1;
        tx_step(mk_tx(1'b1, 1'b0, 1'b1, 1'b0, FIRST_ATTEMPT, UNI));
        tx_step(mk_tx(1'b1, 1'b0, 1'b1, 1'b0, 5'h02, UNI));
        exp.excess_collision_abort_count += 32'h1;
        tx_step(mk_tx(1'b0, 1'b0, 1'b0, 1'b0, LIM, UNI));
        tx_step(mk_tx(1'b0, 1'b0, 1'b0, 1'b0, LIM - 5'h01, UNI));
        exp.excess_deferral_count += 32'h1;
        tx_step(mk_tx(1'b1, 1'b0, 1'b0, 1'b1, FIRST_ATTEMPT, UNI));
        exp.internal_tx_loss_count += 32'h1;
        tx_step(mk_tx(1'b1, 1'b1, 1'b1, 1'b1, FIRST_ATTEMPT, BCAST_ADDR));
    endtask

    // unicast filtering with promiscuous mode off, on and off again
    task automatic t_promisc();
        exp.rx_good_octet_count += 32'(OCT);
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, STN));
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, UNI));
        set_promisc(1'b1);
        exp.rx_good_octet_count += 32'(OCT);
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, UNI));
        exp.length_mismatch_count += 32'h1;
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, 16'h0064, 16'h005A, OCT, UNI));
        set_promisc(1'b0);
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, UNI));
    endtask

    // length field boundaries and receive error statuses
    task automatic t_rx_errors();
        exp.length_mismatch_count += 32'h1;
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, 16'h0014, 16'h0014, OCT, STN));
        exp.length_out_of_range_count += 32'h1;
        exp.rx_good_octet_count       += 32'(OCT);
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, 16'h05DD, 16'h05DD, OCT, STN));
        exp.rx_good_octet_count += 32'(MAX_DATA_LEN);
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, MAX_DATA_LEN, MAX_DATA_LEN, MAX_DATA_LEN, STN));
        exp.oversize_frame_count += 32'h1;
        rx_step(mk_rx(1'b0, 1'b0, 1'b1, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, STN));
        rx_step(mk_rx(1'b0, 1'b0, 1'b0, 1'b1, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, BCAST_ADDR));
    endtask

    // multicast table life cycle, broadcast and internal loss
    task automatic t_group();
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, GRP));
        group_op(1'b1, {1'b1, GRP});
        exp.mcast_rx_count      += 32'h1;
        exp.rx_good_octet_count += 32'(OCT);
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, GRP));
        exp.bcast_rx_count      += 32'h1;
        exp.rx_good_octet_count += 32'(OCT);
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, BCAST_ADDR));
        exp.internal_rx_loss_count += 32'h1;
        rx_step(mk_rx(1'b1, 1'b1, 1'b0, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, BCAST_ADDR));
        group_op(1'b0, '0);
        rx_step(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, MIN_UNPAD_LEN, MIN_UNPAD_LEN, OCT, GRP));
    endtask

    // filter pin read while a report stands with no done pulse
    task automatic t_filter();
        i_far.show_rx(mk_rx(1'b1, 1'b0, 1'b0, 1'b0, OCT, OCT, OCT, UNI));
        compare(SW'(addr_accept), SW'(1'b0));
        set_promisc(1'b1);
        compare(SW'(addr_accept), SW'(1'b1));
        set_promisc(1'b0);
        compare(SW'(addr_accept), SW'(1'b0));
    endtask

    // fill the table; a ninth add must leave slot 0 alone
    task automatic t_full();
        for (int k = 0; k <= GRP_DEPTH; k++) begin
            @(negedge clock);
            group_add  = 1'b1;
            group_addr = GRP + ADDR_W'(k);
        end
        @(negedge clock);
        group_add = 1'b0;
        compare(SW'(list_full), SW'(1'b1));
        @(negedge clock);
        compare(SW'({list_valid, list_entry}), SW'({1'b1, GRP}));
    endtask

    // reset for 8 cycles, then each scenario in turn
    initial begin
        rst_b         = 1'b0;
        promisc_set   = 1'b0;
        promisc_value = 1'b0;
        group_add     = 1'b0;
        group_del     = 1'b0;
        group_addr    = '0;
        list_index    = 3'h0;
        exp           = '0;
        miscompares     = 0;
        samples_checked = 0;
        cycles          = 0;
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        t_reset();
        t_tx();
        t_promisc();
        t_rx_errors();
        t_group();
        t_filter();
        t_full();
        close_out();
    end
endmodule
